//--- core/jdbp_pkg.sv
// Package for the test access port: opcodes, data register layouts and encodings.
// Assumes a four-bit instruction register and least significant bit first shifting.
package jdbp_pkg;

  // ----------------------------------------------------------------
  // instruction register
  // ----------------------------------------------------------------
  localparam int IR_W = 4;
  localparam logic [3:0] OP_EXTEST = 4'h0;
  localparam logic [3:0] OP_IDCODE = 4'h1;
  localparam logic [3:0] OP_SAMPLE = 4'h2;
  localparam logic [3:0] OP_DBG_MBOX = 4'h8;
  localparam logic [3:0] OP_DBG_SCAN = 4'h9;
  localparam logic [3:0] OP_DBG_BRK = 4'ha;
  localparam logic [3:0] OP_DBG_SCAN2 = 4'hb;
  localparam logic [3:0] OP_CHIP_RST = 4'hc;
  localparam logic [3:0] OP_BYPASS = 4'hf;
  localparam logic [3:0] IR_CAPTURE = 4'h1;

  // ----------------------------------------------------------------
  // identification word (all three values arbitrary)
  // ----------------------------------------------------------------
  localparam logic [3:0] ID_VERSION = 4'h0;
  localparam logic [15:0] ID_PART = 16'h5a3c;
  localparam logic [10:0] ID_MANUF = 11'h2b5;

  // ----------------------------------------------------------------
  // boundary chain layout
  // ----------------------------------------------------------------
  localparam int NPINS = 8;
  localparam int NANA = 2;
  localparam int BS_PIN_STRIDE = 3;
  localparam int BS_IN = 0;
  localparam int BS_OUT = 1;
  localparam int BS_OE = 2;
  localparam int BS_ANA_BASE = NPINS * BS_PIN_STRIDE;
  localparam int ANA_OBS = 0;
  localparam int ANA_DRV = 1;
  localparam int BS_W = BS_ANA_BASE + NANA * 2;

  // ----------------------------------------------------------------
  // break configuration word and mailbox data register
  // ----------------------------------------------------------------
  localparam int ADDR_W = 16;
  localparam int BRK_SLOTS = 4;
  localparam int CFG_MODE_LSB = 64;
  localparam int CFG_FLOW_BIT = 67;
  localparam int CFG_STEP_BIT = 68;
  localparam int CFG_EN_LSB = 69;
  localparam int BRK_W = 73;
  localparam logic [2:0] MODE_4P = 3'h0;
  localparam logic [2:0] MODE_3P1D = 3'h1;
  localparam logic [2:0] MODE_2P2D = 3'h2;
  localparam logic [2:0] MODE_PRANGE = 3'h3;
  localparam logic [2:0] MODE_DRANGE = 3'h4;
  localparam int MBOX_CLR_BIT = 8;
  localparam int MBOX_EN_BIT = 9;
  localparam int DR_W = BRK_W;

  localparam logic [6:0] LEN_ONE = 7'd1;
  localparam logic [6:0] LEN_ID = 7'd32;
  localparam logic [6:0] LEN_BS = 7'd28;
  localparam logic [6:0] LEN_MBOX = 7'd10;
  localparam logic [6:0] LEN_BRK = 7'd73;

  typedef enum logic [2:0] {
    KIND_PROG = 3'b000,
    KIND_DATA = 3'b001,
    KIND_MASK = 3'b010,
    KIND_PRANGE = 3'b011,
    KIND_DRANGE = 3'b100
  } jdbp_kind_e;

  typedef enum logic [2:0] {
    DR_BYPASS = 3'b000,
    DR_ID = 3'b001,
    DR_BS = 3'b010,
    DR_RST = 3'b011,
    DR_MBOX = 3'b100,
    DR_SCAN = 3'b101,
    DR_BRK = 3'b110
  } jdbp_dr_e;

  typedef enum logic [3:0] {
    ST_TLR = 4'b0000,
    ST_RTI = 4'b0001,
    ST_SELDR = 4'b0010,
    ST_CAPDR = 4'b0011,
    ST_SHDR = 4'b0100,
    ST_EX1DR = 4'b0101,
    ST_PAUDR = 4'b0110,
    ST_EX2DR = 4'b0111,
    ST_UPDR = 4'b1000,
    ST_SELIR = 4'b1001,
    ST_CAPIR = 4'b1010,
    ST_SHIR = 4'b1011,
    ST_EX1IR = 4'b1100,
    ST_PAUIR = 4'b1101,
    ST_EX2IR = 4'b1110,
    ST_UPIR = 4'b1111
  } jdbp_tap_e;

endpackage

//--- core/jdbp_port.sv
// Test access port: boundary scan, identification, chip reset, debug mailbox and break unit.
// Assumes tck is the probe's clock, unrelated to sys_clk; fuse and lock inputs are sys_clk levels.
module jdbp_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic clkEn,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdoEn,
  input wire logic portEnFuse,
  input wire logic debugEnFuse,
  input wire logic lockBitOne,
  input wire logic lockBitTwo,
  input wire logic portDisableBit,
  input wire logic dbgFuseProgReq,
  output logic dbgFuseProgGrant,
  input wire logic extResetN,
  output logic deviceReset,
  input wire logic cpuSel,
  input wire logic cpuWr,
  input wire logic [7:0] cpuWdata,
  output logic [7:0] cpuRdata,
  input wire logic [7:0] stdIoRdata,
  output logic stdIoSel,
  output logic cpuScanTdi,
  output logic cpuScanCapture,
  output logic cpuScanShift,
  output logic cpuScanUpdate,
  input wire logic cpuScanTdo,
  input wire logic [15:0] pcAddr,
  input wire logic pcValid,
  input wire logic [15:0] dataAddr,
  input wire logic dataValid,
  input wire logic flowChange,
  output logic breakReq,
  input wire logic [7:0] coreOut,
  input wire logic [7:0] coreOe,
  input wire logic [7:0] padIn,
  output logic [7:0] padOut,
  output logic [7:0] padOe,
  input wire logic [1:0] anaDrive,
  input wire logic [1:0] anaObserve,
  output logic [1:0] anaOut
);

  localparam int DW = jdbp_pkg::DR_W;

  function automatic jdbp_pkg::jdbp_kind_e brk_kind(input logic [2:0] mode, input int slot);
    if (slot < 2) begin
      return jdbp_pkg::KIND_PROG;
    end
    case (mode)
      jdbp_pkg::MODE_4P: return jdbp_pkg::KIND_PROG;
      jdbp_pkg::MODE_3P1D: return (slot == 2) ? jdbp_pkg::KIND_PROG : jdbp_pkg::KIND_DATA;
      jdbp_pkg::MODE_2P2D: return jdbp_pkg::KIND_DATA;
      jdbp_pkg::MODE_PRANGE: return (slot == 2) ? jdbp_pkg::KIND_PRANGE : jdbp_pkg::KIND_MASK;
      jdbp_pkg::MODE_DRANGE: return (slot == 2) ? jdbp_pkg::KIND_DRANGE : jdbp_pkg::KIND_MASK;
      default: return jdbp_pkg::KIND_MASK;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // test clock reset and domain crossings
  // ----------------------------------------------------------------
  logic [2:0] rstSyncT;
  logic tckRstN;
  logic tapRst;
  logic portActive;
  logic debugOk;
  logic dirty;
  logic [7:0] mailbox;
  logic [2:0] toTck;
  logic [2:0] sT1, sT2, sT3, qT;
  logic dirtyT, debugOkT, portActT;
  logic mboxEnT, clrTogT, cfgTogT;
  logic [jdbp_pkg::BRK_W-1:0] cfgT;
  logic [2:0] fromTck;
  logic [2:0] sS1, sS2, sS3, qS, qSd;

  // no reset here: these flops are what produce the test clock reset
  always_ff @(posedge tck) begin
    rstSyncT <= {rstSyncT[1:0], rst_n};
    if (rstSyncT[1] == rstSyncT[2]) begin
      tckRstN <= rstSyncT[2];
    end
  end

  assign toTck = {dirty, debugOk, portActive};
  // a level counts once the second and third stages agree
  always_ff @(posedge tck) begin
    if (!tckRstN) begin
      sT1 <= 3'h0;
      sT2 <= 3'h0;
      sT3 <= 3'h0;
      qT <= 3'h0;
    end else begin
      sT1 <= toTck;
      sT2 <= sT1;
      sT3 <= sT2;
      qT <= (qT & (sT2 ^ sT3)) | (sT3 & ~(sT2 ^ sT3));
    end
  end
  assign dirtyT = qT[2];
  assign debugOkT = qT[1];
  assign portActT = qT[0];
  assign tapRst = !tckRstN || !portActT;

  // ----------------------------------------------------------------
  // controller and instruction register
  // ----------------------------------------------------------------
  jdbp_tap_if tap ();
  jdbp_tap_fsm u_fsm (
    .tck(tck),
    .tapRst(tapRst),
    .tms(tms),
    .tap(tap)
  );

  logic [3:0] ir, irShift;
  always_ff @(posedge tck) begin
    if (tapRst || tap.tlr) begin
      ir <= jdbp_pkg::OP_IDCODE;
      irShift <= 4'h0;
    end else if (tap.captureIr) begin
      irShift <= jdbp_pkg::IR_CAPTURE;
    end else if (tap.shiftIr) begin
      irShift <= {tdi, irShift[3:1]};
    end else if (tap.updateIr) begin
      ir <= irShift;
    end
  end

  // private opcodes fall back to bypass while debug is locked out
  jdbp_pkg::jdbp_dr_e drSel;
  logic isPrivate, extest;
  assign isPrivate = (ir >= jdbp_pkg::OP_DBG_MBOX) && (ir <= jdbp_pkg::OP_DBG_SCAN2) && debugOkT;
  assign extest = (ir == jdbp_pkg::OP_EXTEST);
  assign drSel = (ir == jdbp_pkg::OP_IDCODE) ? jdbp_pkg::DR_ID :
                 (extest || ir == jdbp_pkg::OP_SAMPLE) ? jdbp_pkg::DR_BS :
                 (ir == jdbp_pkg::OP_CHIP_RST) ? jdbp_pkg::DR_RST :
                 (isPrivate && ir == jdbp_pkg::OP_DBG_MBOX) ? jdbp_pkg::DR_MBOX :
                 (isPrivate && ir == jdbp_pkg::OP_DBG_BRK) ? jdbp_pkg::DR_BRK :
                 isPrivate ? jdbp_pkg::DR_SCAN : jdbp_pkg::DR_BYPASS;

  // ----------------------------------------------------------------
  // boundary chain: pins and analog interface
  // ----------------------------------------------------------------
  logic [jdbp_pkg::BS_W-1:0] bsCapture, bsLatch;
  logic [7:0] bsOeLatch;
  for (genvar p = 0; p < jdbp_pkg::NPINS; p++) begin : g_pin
    assign bsCapture[p*jdbp_pkg::BS_PIN_STRIDE+jdbp_pkg::BS_IN] = padIn[p];
    assign bsCapture[p*jdbp_pkg::BS_PIN_STRIDE+jdbp_pkg::BS_OUT] = coreOut[p];
    assign bsCapture[p*jdbp_pkg::BS_PIN_STRIDE+jdbp_pkg::BS_OE] = coreOe[p];
    assign bsOeLatch[p] = bsLatch[p*jdbp_pkg::BS_PIN_STRIDE+jdbp_pkg::BS_OE];
    // latches reach the pins as soon as external test is the instruction
    assign padOut[p] = extest ? bsLatch[p*jdbp_pkg::BS_PIN_STRIDE+jdbp_pkg::BS_OUT] : coreOut[p];
    assign padOe[p] = extest ? bsOeLatch[p] : (coreOe[p] & ~deviceReset);
  end
  for (genvar a = 0; a < jdbp_pkg::NANA; a++) begin : g_ana
    assign bsCapture[jdbp_pkg::BS_ANA_BASE+a*2+jdbp_pkg::ANA_OBS] = anaObserve[a];
    assign bsCapture[jdbp_pkg::BS_ANA_BASE+a*2+jdbp_pkg::ANA_DRV] = anaDrive[a];
    assign anaOut[a] = extest ? bsLatch[jdbp_pkg::BS_ANA_BASE+a*2+jdbp_pkg::ANA_DRV] : anaDrive[a];
  end

  // ----------------------------------------------------------------
  // shared data shift register
  // ----------------------------------------------------------------
  logic [DW-1:0] drShift, drCapture, lenBit, next_drShift;
  logic [6:0] drLen;
  logic rstReg;
  logic [7:0] mboxView;

  // byte is only trusted once the dirty flag has crossed, so it has long settled
  assign mboxView = dirtyT ? mailbox : 8'h00;
  assign drLen = (drSel == jdbp_pkg::DR_ID) ? jdbp_pkg::LEN_ID :
                 (drSel == jdbp_pkg::DR_BS) ? jdbp_pkg::LEN_BS :
                 (drSel == jdbp_pkg::DR_MBOX) ? jdbp_pkg::LEN_MBOX :
                 (drSel == jdbp_pkg::DR_BRK) ? jdbp_pkg::LEN_BRK : jdbp_pkg::LEN_ONE;
  assign drCapture = (drSel == jdbp_pkg::DR_ID) ?
                       DW'({jdbp_pkg::ID_VERSION, jdbp_pkg::ID_PART, jdbp_pkg::ID_MANUF, 1'b1}) :
                     (drSel == jdbp_pkg::DR_BS) ? DW'(bsCapture) :
                     (drSel == jdbp_pkg::DR_MBOX) ? DW'({mboxEnT, dirtyT, mboxView}) :
                     (drSel == jdbp_pkg::DR_BRK) ? cfgT : '0;
  assign lenBit = DW'(1) << (drLen - 7'd1);
  assign next_drShift = (drShift >> 1) | (tdi ? lenBit : '0);

  always_ff @(posedge tck) begin
    if (tapRst) begin
      drShift <= '0;
    end else if (tap.captureDr) begin
      drShift <= drCapture;
    end else if (tap.shiftDr) begin
      drShift <= next_drShift;
    end
  end

  // unlatched: reset follows the bit as it is shifted
  always_ff @(posedge tck) begin
    if (tapRst || tap.tlr) begin
      rstReg <= 1'b0;
    end else if (tap.shiftDr && drSel == jdbp_pkg::DR_RST) begin
      rstReg <= tdi;
    end
  end
  assign deviceReset = !extResetN || rstReg;

  always_ff @(posedge tck) begin
    if (tapRst) begin
      bsLatch <= '0;
      mboxEnT <= 1'b0;
      clrTogT <= 1'b0;
      cfgT <= '0;
      cfgTogT <= 1'b0;
    end else if (tap.updateDr) begin
      if (drSel == jdbp_pkg::DR_BS) begin
        bsLatch <= drShift[jdbp_pkg::BS_W-1:0];
      end
      if (drSel == jdbp_pkg::DR_MBOX) begin
        mboxEnT <= drShift[jdbp_pkg::MBOX_EN_BIT];
        if (drShift[jdbp_pkg::MBOX_CLR_BIT]) begin
          clrTogT <= ~clrTogT;
        end
      end
      if (drSel == jdbp_pkg::DR_BRK) begin
        cfgT <= drShift;
        cfgTogT <= ~cfgTogT;
      end
    end
  end

  // CPU chain is driven straight from the link
  assign cpuScanTdi = tdi;
  assign cpuScanCapture = tap.captureDr && drSel == jdbp_pkg::DR_SCAN;
  assign cpuScanShift = tap.shiftDr && drSel == jdbp_pkg::DR_SCAN;
  assign cpuScanUpdate = tap.updateDr && drSel == jdbp_pkg::DR_SCAN;

  // ----------------------------------------------------------------
  // serial output, launched on the falling edge
  // ----------------------------------------------------------------
  logic tdoBit;
  assign tdoBit = tap.shiftIr ? irShift[0] :
                  (drSel == jdbp_pkg::DR_RST) ? rstReg :
                  (drSel == jdbp_pkg::DR_SCAN) ? cpuScanTdo : drShift[0];
  always_ff @(negedge tck) begin
    if (tapRst) begin
      tdo <= 1'b0;
      tdoEn <= 1'b0;
    end else begin
      tdo <= tdoBit;
      tdoEn <= tap.shiftIr || tap.shiftDr;
    end
  end

  // ----------------------------------------------------------------
  // system clock side: enables, mailbox, break unit
  // ----------------------------------------------------------------
  logic mboxEnS, clrEvent, cfgEvent, mailboxSel, cpuMboxWr;
  logic [jdbp_pkg::BRK_W-1:0] cfgSys;
  logic [3:0] slotHit;
  logic [2:0] brkMode;

  assign fromTck = {cfgTogT, clrTogT, mboxEnT};
  assign mboxEnS = qS[0];
  assign clrEvent = qS[1] ^ qSd[1];
  assign cfgEvent = qS[2] ^ qSd[2];
  assign mailboxSel = debugEnFuse && mboxEnS;
  assign cpuMboxWr = cpuSel && cpuWr && mailboxSel;
  assign stdIoSel = cpuSel && !mailboxSel;
  assign cpuRdata = mailboxSel ? {dirty, mailbox[6:0]} : stdIoRdata;
  assign dbgFuseProgGrant = dbgFuseProgReq && !(lockBitOne || lockBitTwo);
  assign brkMode = cfgSys[jdbp_pkg::CFG_MODE_LSB +: 3];

  for (genvar s = 0; s < jdbp_pkg::BRK_SLOTS; s++) begin : g_slot
    jdbp_pkg::jdbp_kind_e kind;
    logic isData;
    logic [15:0] msk, addr;
    assign kind = brk_kind(brkMode, s);
    assign isData = (kind == jdbp_pkg::KIND_DATA) || (kind == jdbp_pkg::KIND_DRANGE);
    assign msk = (kind == jdbp_pkg::KIND_PRANGE || kind == jdbp_pkg::KIND_DRANGE) ?
                 cfgSys[3*jdbp_pkg::ADDR_W +: jdbp_pkg::ADDR_W] : 16'hffff;
    assign addr = isData ? dataAddr : pcAddr;
    assign slotHit[s] = cfgSys[jdbp_pkg::CFG_EN_LSB+s] && kind != jdbp_pkg::KIND_MASK &&
                        (isData ? dataValid : pcValid) &&
                        (((addr ^ cfgSys[s*jdbp_pkg::ADDR_W +: jdbp_pkg::ADDR_W]) & msk) == 16'h0000);
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      portActive <= 1'b0;
      debugOk <= 1'b0;
      dirty <= 1'b0;
      mailbox <= 8'h00;
      sS1 <= 3'h0;
      sS2 <= 3'h0;
      sS3 <= 3'h0;
      qS <= 3'h0;
      qSd <= 3'h0;
      cfgSys <= '0;
      breakReq <= 1'b0;
    end else if (clkEn) begin
      portActive <= portEnFuse && !portDisableBit;
      debugOk <= portEnFuse && debugEnFuse && !lockBitOne && !lockBitTwo;
      sS1 <= fromTck;
      sS2 <= sS1;
      sS3 <= sS2;
      qS <= (qS & (sS2 ^ sS3)) | (sS3 & ~(sS2 ^ sS3));
      qSd <= qS;
      if (cpuMboxWr) begin
        mailbox <= cpuWdata;
      end
      // a write in the clearing cycle keeps the flag set
      dirty <= cpuMboxWr || (dirty && !clrEvent);
      if (cfgEvent) begin
        cfgSys <= cfgT;
      end
      breakReq <= debugOk && ((|slotHit) || (cfgSys[jdbp_pkg::CFG_FLOW_BIT] && flowChange) ||
                  (cfgSys[jdbp_pkg::CFG_STEP_BIT] && pcValid));
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_ir_default_id: assert property (@(posedge tck) disable iff (!tckRstN)
    tap.tlr |=> ir == jdbp_pkg::OP_IDCODE) else $error("identification not default");
  a_ir_capture_value: assert property (@(posedge tck) disable iff (tapRst)
    tap.captureIr |=> irShift == 4'h1) else $error("instruction capture value wrong");
  a_bypass_zero: assert property (@(posedge tck) disable iff (tapRst)
    (tap.captureDr && drSel == jdbp_pkg::DR_BYPASS) |=> !drShift[0]) else $error("bypass not zero");
  a_reset_bit_now: assert property (@(posedge tck) disable iff (tapRst)
    (tap.shiftDr && drSel == jdbp_pkg::DR_RST && tdi) |=> deviceReset) else $error("reset late");
  a_extest_pins: assert property (@(posedge tck) disable iff (tapRst)
    (tap.updateIr && irShift == jdbp_pkg::OP_EXTEST) |=> padOe == bsOeLatch)
    else $error("latches not on pins under external test");
  a_hiz_reset: assert property (@(posedge tck) disable iff (tapRst)
    (!extest && deviceReset) |-> padOe == 8'h00) else $error("pins driven in reset");
  a_private_gate: assert property (@(posedge tck) disable iff (tapRst)
    (drSel == jdbp_pkg::DR_SCAN || drSel == jdbp_pkg::DR_MBOX || drSel == jdbp_pkg::DR_BRK)
    |-> debugOkT && ir >= 4'h8 && ir <= 4'hb) else $error("debug path open without permission");
  a_mbox_write_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (cpuMboxWr && clkEn) ##1 mailboxSel |-> cpuRdata == {1'b1, $past(cpuWdata[6:0])})
    else $error("mailbox write not visible with dirty flag");
  a_debug_locked: assert property (@(posedge sys_clk) disable iff (!rst_n)
    ((lockBitOne || lockBitTwo) && clkEn) |=> !debugOk) else $error("debug alive with lock bit");
  a_fuse_refused: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (lockBitOne || lockBitTwo) |-> !dbgFuseProgGrant) else $error("debug fuse granted on locked part");

endmodule

//--- core/jdbp_tap_fsm.sv
// Sixteen-state test controller stepped by the mode-select level.
// Assumes tapRst is synchronous to tck and held while the port is disabled.
module jdbp_tap_fsm (
  input wire logic tck,
  input wire logic tapRst,
  input wire logic tms,
  jdbp_tap_if.fsm tap
);

  jdbp_pkg::jdbp_tap_e state;
  jdbp_pkg::jdbp_tap_e next_state;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    case (state)
      jdbp_pkg::ST_TLR: next_state = tms ? jdbp_pkg::ST_TLR : jdbp_pkg::ST_RTI;
      jdbp_pkg::ST_RTI: next_state = tms ? jdbp_pkg::ST_SELDR : jdbp_pkg::ST_RTI;
      jdbp_pkg::ST_SELDR: next_state = tms ? jdbp_pkg::ST_SELIR : jdbp_pkg::ST_CAPDR;
      jdbp_pkg::ST_CAPDR: next_state = tms ? jdbp_pkg::ST_EX1DR : jdbp_pkg::ST_SHDR;
      jdbp_pkg::ST_SHDR: next_state = tms ? jdbp_pkg::ST_EX1DR : jdbp_pkg::ST_SHDR;
      jdbp_pkg::ST_EX1DR: next_state = tms ? jdbp_pkg::ST_UPDR : jdbp_pkg::ST_PAUDR;
      jdbp_pkg::ST_PAUDR: next_state = tms ? jdbp_pkg::ST_EX2DR : jdbp_pkg::ST_PAUDR;
      jdbp_pkg::ST_EX2DR: next_state = tms ? jdbp_pkg::ST_UPDR : jdbp_pkg::ST_SHDR;
      jdbp_pkg::ST_UPDR: next_state = tms ? jdbp_pkg::ST_SELDR : jdbp_pkg::ST_RTI;
      jdbp_pkg::ST_SELIR: next_state = tms ? jdbp_pkg::ST_TLR : jdbp_pkg::ST_CAPIR;
      jdbp_pkg::ST_CAPIR: next_state = tms ? jdbp_pkg::ST_EX1IR : jdbp_pkg::ST_SHIR;
      jdbp_pkg::ST_SHIR: next_state = tms ? jdbp_pkg::ST_EX1IR : jdbp_pkg::ST_SHIR;
      jdbp_pkg::ST_EX1IR: next_state = tms ? jdbp_pkg::ST_UPIR : jdbp_pkg::ST_PAUIR;
      jdbp_pkg::ST_PAUIR: next_state = tms ? jdbp_pkg::ST_EX2IR : jdbp_pkg::ST_PAUIR;
      jdbp_pkg::ST_EX2IR: next_state = tms ? jdbp_pkg::ST_UPIR : jdbp_pkg::ST_SHIR;
      jdbp_pkg::ST_UPIR: next_state = tms ? jdbp_pkg::ST_SELDR : jdbp_pkg::ST_RTI;
      default: next_state = jdbp_pkg::ST_TLR;
    endcase
  end

  always_ff @(posedge tck) begin
    if (tapRst) begin
      state <= jdbp_pkg::ST_TLR;
    end else begin
      state <= next_state;
    end
  end

  assign tap.tlr = (state == jdbp_pkg::ST_TLR);
  assign tap.captureDr = (state == jdbp_pkg::ST_CAPDR);
  assign tap.shiftDr = (state == jdbp_pkg::ST_SHDR);
  assign tap.updateDr = (state == jdbp_pkg::ST_UPDR);
  assign tap.captureIr = (state == jdbp_pkg::ST_CAPIR);
  assign tap.shiftIr = (state == jdbp_pkg::ST_SHIR);
  assign tap.updateIr = (state == jdbp_pkg::ST_UPIR);

  a_tlr_five_ones: assert property (@(posedge tck) disable iff (tapRst)
    tms [*5] |=> tap.tlr) else $error("five high mode-select clocks did not reach reset state");

endmodule

//--- core/jdbp_tap_if.sv
// Decoded controller states passed from the state machine to the port logic.
// Assumes both ends sit in the test clock domain.
interface jdbp_tap_if;
  logic tlr;
  logic captureDr;
  logic shiftDr;
  logic updateDr;
  logic captureIr;
  logic shiftIr;
  logic updateIr;
  modport fsm (output tlr, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr);
  modport user (input tlr, captureDr, shiftDr, updateDr, captureIr, shiftIr, updateIr);
endinterface

//--- tb/jdbp_port_tb.sv
// Testbench for the test access port.
// Assumes the probe model sits on the link; cpu side driven on falling sys_clk.
module jdbp_port_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk = 0, rst_n = 0, tck, tms, tdi, tdo, fuseEn = 1, lockOne = 0, extResetN = 1;
  logic cpuSel = 0, cpuWr = 0, deviceReset, grant, lo = 0;
  logic clkEn = 1, portEn = 1, fuseReq = 1, pcValid = 0, brk;
  logic [7:0] coreOe = 8'hff;
  logic [1:0] anaOut;
  logic [7:0] cpuWdata = 0, padIn = 8'ha5, cpuRdata, padOut, padOe;
  logic [72:0] q;
  int n_fail = 0, check_count = 0;
  always #12.5 sys_clk = ~sys_clk;
  jdbp_probe probe (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  jdbp_port uut (.sys_clk(sys_clk), .rst_n(rst_n), .clkEn(clkEn), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoEn(), .portEnFuse(portEn), .debugEnFuse(fuseEn),
    .lockBitOne(lockOne), .lockBitTwo(lo), .portDisableBit(lo), .dbgFuseProgReq(fuseReq),
    .dbgFuseProgGrant(grant), .extResetN(extResetN), .deviceReset(deviceReset),
    .cpuSel(cpuSel), .cpuWr(cpuWr), .cpuWdata(cpuWdata), .cpuRdata(cpuRdata),
    .stdIoRdata(8'h3c), .stdIoSel(), .cpuScanTdi(), .cpuScanCapture(), .cpuScanShift(),
    .cpuScanUpdate(), .cpuScanTdo(lo), .pcAddr(16'h0000), .pcValid(pcValid),
    .dataAddr(16'h0000), .dataValid(lo), .flowChange(lo), .breakReq(brk),
    .coreOut(cpuWdata), .coreOe(coreOe), .padIn(padIn), .padOut(padOut), .padOe(padOe),
    .anaDrive(2'h1), .anaObserve(2'h2), .anaOut(anaOut));
  task automatic chk(input logic [72:0] g, input logic [72:0] e);
    check_count++;
    if (g !== e) begin
      n_fail++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic close_out();
    $display("checks %0d errors %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #500000;
    n_fail++;
    close_out();
  end
  initial begin
    fork
      repeat (6) @(negedge sys_clk);
      probe.idle(12, 1'b1);
    join
    @(negedge sys_clk) rst_n = 1;
    probe.idle(10, 1'b1);
    probe.idle(1, 1'b0);
    chk(grant, 1'b1);
    @(negedge sys_clk) fuseReq = 0;
    @(negedge sys_clk) chk(grant, 1'b0);
    fuseReq = 1;
    probe.scan(1'b0, 32, 0, q);
    chk(q[31:0], {jdbp_pkg::ID_VERSION, jdbp_pkg::ID_PART, jdbp_pkg::ID_MANUF, 1'b1});
    probe.scan(1'b1, 4, jdbp_pkg::OP_BYPASS, q);
    chk(q[3:0], jdbp_pkg::IR_CAPTURE);
    probe.scan(1'b0, 2, 2'b11, q);
    chk(q[1:0], 2'b10);
    probe.scan(1'b1, 4, jdbp_pkg::OP_CHIP_RST, q);
    probe.scan(1'b0, 1, 1, q);
    chk({deviceReset, padOe}, 9'h100);
    probe.scan(1'b0, 1, 0, q);
    chk(deviceReset, 1'b0);
    @(negedge sys_clk) extResetN = 0;
    @(negedge sys_clk) chk(deviceReset, 1'b1);
    extResetN = 1;
    // safe preload first, so extest drives known levels
    probe.scan(1'b1, 4, jdbp_pkg::OP_SAMPLE, q);
    probe.scan(1'b0, 28, 28'h0db6db6, q);
    chk({padOut, padOe}, 16'h00ff);
    probe.scan(1'b1, 4, jdbp_pkg::OP_EXTEST, q);
    chk({padOut, padOe}, 16'hffff);
    chk(anaOut, 2'h0);
    probe.scan(1'b0, 28, 0, q);
    for (int p = 0; p < 8; p++) chk(q[3 * p], padIn[p]);
    chk(q[27:24], 4'h6);
    probe.scan(1'b1, 4, jdbp_pkg::OP_DBG_MBOX, q);
    probe.scan(1'b0, 10, 10'h200, q);
    repeat (10) @(negedge sys_clk);
    cpuSel = 1;
    cpuWr = 1;
    cpuWdata = 8'hd5;
    @(negedge sys_clk) cpuWr = 0;
    chk(cpuRdata, 8'hd5);
    repeat (10) @(negedge sys_clk);
    // link clock only runs in frames: give the dirty flag tck edges to cross
    probe.idle(6, 1'b0);
    probe.scan(1'b0, 10, 10'h300, q);
    chk(q[9:0], 10'h3d5);
    repeat (10) @(negedge sys_clk);
    chk(cpuRdata, 8'h55);
    clkEn = 0;
    cpuWr = 1;
    cpuWdata = 8'h11;
    @(negedge sys_clk) cpuWr = 0;
    clkEn = 1;
    chk(cpuRdata, 8'h55);
    probe.scan(1'b1, 4, jdbp_pkg::OP_DBG_BRK, q);
    probe.scan(1'b0, 73, 73'h1 << jdbp_pkg::CFG_EN_LSB, q);
    repeat (8) @(negedge sys_clk);
    chk(brk, 1'b0);
    pcValid = 1;
    @(negedge sys_clk) pcValid = 0;
    chk(brk, 1'b1);
    fuseEn = 0;
    repeat (4) @(negedge sys_clk);
    chk(cpuRdata, 8'h3c);
    fuseEn = 1;
    lockOne = 1;
    repeat (4) @(negedge sys_clk);
    chk(grant, 1'b0);
    // a locked part must treat the debug opcode as bypass
    probe.scan(1'b1, 4, jdbp_pkg::OP_DBG_MBOX, q);
    probe.scan(1'b0, 2, 2'b11, q);
    chk(q[1:0], 2'b10);
    portEn = 0;
    repeat (4) @(negedge sys_clk);
    probe.idle(8, 1'b1);
    probe.idle(1, 1'b0);
    probe.scan(1'b0, 32, 32'hffffffff, q);
    chk(q[31:0], 32'h0);
    close_out();
  end
endmodule

//--- tb/jdbp_probe.sv
// Debugger probe model: drives the four-wire link, owns the link clock.
// Assumes the port samples on rising tck and launches tdo on falling tck.
module jdbp_probe (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
  end
  // clock only runs inside frames, 15 ns period
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #7.5;
    o = tdo;
    tck = 1'b1;
    #7.5;
    tck = 1'b0;
  endtask
  task automatic idle(input int n, input logic m);
    logic o;
    repeat (n) step(m, 1'b1, o);
  endtask
  // from idle to shift, n bits, back to idle
  task automatic scan(input logic ir, input int n, input logic [72:0] din,
                      output logic [72:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b0, o);
    if (ir) step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
    step(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b0, o);
    step(1'b0, 1'b0, o);
  endtask
endmodule
